//--- logic/tgt_cfg_pkg.sv
// Purpose: constants for the target path config/status register bank
// Assumes: APB slave, 32-bit data, word aligned registers
// Notes: offsets are byte addresses
package tgt_cfg_pkg;
	localparam logic [11:0] CFG_OFFSET = 12'h090;
	localparam logic [11:0] STATUS_OFFSET = 12'h094;
	localparam logic [11:0] MASK_OFFSET = 12'h098;
	localparam int ADDR_W = 16;
	localparam logic [15:0] CFG_ADDR = 16'hD090;
	localparam logic [15:0] STAT_ADDR = 16'hD094;
	localparam logic [15:0] MASK_ADDR = 16'hD098;
	localparam int WIN1_PD_BIT = 11;
	localparam int WIN2_PD_BIT = 10;
	localparam int TOB_FLUSH_BIT = 9;
	localparam int TIB_FLUSH_BIT = 8;
	localparam int PSC_BIT = 24;
	localparam int WES_BIT = 23;
	localparam int WSC_BIT = 22;
	localparam int M66_BIT = 21;
	localparam int IOBE_BIT = 20;
	localparam int IIBE_BIT = 19;
	localparam int TOBE_BIT = 18;
	localparam int TIBE_BIT = 17;
	localparam logic WIN1_PD_RESET = 1'h0;
	localparam logic WIN2_PD_RESET = 1'h1;
	localparam logic EMPTY_RESET = 1'h1;
	localparam int EVENT_W = 3;
	localparam logic [2:0] EVENT_RESET = 3'h0;
endpackage

//--- logic/pm_event_detect.sv
// Purpose: turn host power-management register writes into event pulses
// Assumes: host write strobe and data synchronous to sys_clk_in
// Notes: outputs are one-cycle pulses
`timescale 1ns/1ps
module pm_event_detect (
	// Clock and control
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	// Host write of power-management control/status
	input wire logic pmcsr_wr_in,
	input wire logic power_state_wr_in,
	input wire logic wake_enable_in,
	input wire logic wake_status_clr_in,
	// Events: [2] state changed, [1] enable set, [0] status cleared
	output logic [2:0] event_out
);
	typedef struct packed {
		logic wake_en;
		logic [2:0] ev;
	} state_t;
	state_t state_reg, state_next;
	always_comb begin
		state_next = state_reg;
		state_next.ev = 3'h0;
		if (pmcsr_wr_in) begin
			state_next.ev[2] = power_state_wr_in;
			state_next.ev[1] = wake_enable_in & ~state_reg.wake_en;
			state_next.ev[0] = wake_status_clr_in;
			state_next.wake_en = wake_enable_in;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg <= '0;
		end else if (clk_en_in) begin
			state_reg <= state_next;
		end
	end
	assign event_out = state_reg.ev;
endmodule

//--- logic/flush_tracker.sv
// Purpose: hold a target FIFO flush request until the core finishes
// Assumes: core raises done for one cycle when the flush ends
// Notes: empty override drops when new data enters
`timescale 1ns/1ps
module flush_tracker (
	// Clock and control
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	// Strobe from software, handshake with core
	input wire logic strobe_in,
	input wire logic done_in,
	input wire logic push_in,
	input wire logic core_empty_in,
	// Outputs
	output logic flush_out,
	output logic empty_out
);
	typedef struct packed {
		logic busy;
		logic forced;
		logic empty;
	} state_t;
	state_t state_reg, state_next;
	always_comb begin
		state_next = state_reg;
		if (strobe_in) begin
			state_next.busy = 1'b1;
		end else if (done_in) begin
			state_next.busy = 1'b0;
			state_next.forced = 1'b1;
		end
		if (push_in) begin
			state_next.forced = 1'b0;
		end
		state_next.empty = state_next.forced | core_empty_in;
	end
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg <= '{busy: 1'b0, forced: 1'b0, empty: 1'b1};
		end else if (clk_en_in) begin
			state_reg <= state_next;
		end
	end
	assign flush_out = state_reg.busy;
	assign empty_out = state_reg.empty;
endmodule

//--- logic/tgt_cfg_regs.sv
// Purpose: APB register bank for target path config, status and interrupt
// Assumes: every input is synchronous to sys_clk_in
// Notes: zero wait states; unmapped addresses read 0 and flag pslverr
`timescale 1ns/1ps
module tgt_cfg_regs (
	// Clock and control
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	input wire logic satellite_mode_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [tgt_cfg_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Host power-management writes
	input wire logic pmcsr_wr_in,
	input wire logic power_state_wr_in,
	input wire logic wake_enable_in,
	input wire logic wake_status_clr_in,
	// Live status
	input wire logic m66_enable_in,
	input wire logic init_outbound_empty_in,
	input wire logic init_inbound_empty_in,
	input wire logic tgt_outbound_empty_in,
	input wire logic tgt_inbound_empty_in,
	// FIFO flush handshake
	input wire logic tgt_outbound_done_in,
	input wire logic tgt_inbound_done_in,
	input wire logic tgt_outbound_push_in,
	input wire logic tgt_inbound_push_in,
	output logic tgt_outbound_flush_out,
	output logic tgt_inbound_flush_out,
	// Target burst read control
	input wire logic burst_req_in,
	input wire logic burst_window_two_in,
	output logic burst_refuse_out,
	output logic window_one_prefetch_off_out,
	output logic window_two_prefetch_off_out,
	output logic prefetchable_bar_out,
	// Interrupt
	output logic irq_out
);
	import tgt_cfg_pkg::*;

	typedef struct packed {
		logic win1_pd;
		logic win2_pd;
		logic tob_strobe;
		logic tib_strobe;
		logic [EVENT_W-1:0] events;
		logic [EVENT_W-1:0] mask;
		logic m66;
		logic iobe;
		logic iibe;
		logic refuse;
		logic irq;
		logic [31:0] rdata;
		logic err;
		logic ready;
		logic bar;
	} state_t;

	state_t state_reg, state_next;
	logic [EVENT_W-1:0] pm_event;
	logic tob_empty, tib_empty;
	logic tob_flush, tib_flush;
	logic acc, wr_acc;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == CFG_ADDR) || (a == STAT_ADDR) || (a == MASK_ADDR);
	endfunction

	pm_event_detect u_pm (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.clk_en_in(clk_en_in),
		.pmcsr_wr_in(pmcsr_wr_in),
		.power_state_wr_in(power_state_wr_in),
		.wake_enable_in(wake_enable_in),
		.wake_status_clr_in(wake_status_clr_in),
		.event_out(pm_event)
	);

	flush_tracker u_tob (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.clk_en_in(clk_en_in),
		.strobe_in(state_reg.tob_strobe),
		.done_in(tgt_outbound_done_in),
		.push_in(tgt_outbound_push_in),
		.core_empty_in(tgt_outbound_empty_in),
		.flush_out(tob_flush),
		.empty_out(tob_empty)
	);

	flush_tracker u_tib (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.clk_en_in(clk_en_in),
		.strobe_in(state_reg.tib_strobe),
		.done_in(tgt_inbound_done_in),
		.push_in(tgt_inbound_push_in),
		.core_empty_in(tgt_inbound_empty_in),
		.flush_out(tib_flush),
		.empty_out(tib_empty)
	);

	// Zero-wait slave: every access phase completes in its first cycle
	assign acc = psel_in & penable_in;
	assign wr_acc = acc & pwrite_in;

	always_comb begin
		state_next = state_reg;
		state_next.tob_strobe = 1'b0;
		state_next.tib_strobe = 1'b0;
		state_next.ready = 1'b1;
		// Prefetchable indication is fixed, independent of disable bits
		state_next.bar = 1'b1;
		state_next.m66 = m66_enable_in;
		state_next.iobe = init_outbound_empty_in;
		state_next.iibe = init_inbound_empty_in;
		// Software writes
		if (wr_acc && paddr_in == CFG_ADDR) begin
			state_next.win1_pd = pwdata_in[WIN1_PD_BIT];
			state_next.win2_pd = pwdata_in[WIN2_PD_BIT];
			state_next.tob_strobe = pwdata_in[TOB_FLUSH_BIT];
			state_next.tib_strobe = pwdata_in[TIB_FLUSH_BIT];
		end else if (wr_acc && paddr_in == STAT_ADDR) begin
			// W1C; bit 21 and below ignore writes
			state_next.events = state_reg.events &
				~pwdata_in[PSC_BIT -: EVENT_W];
		end else if (wr_acc && paddr_in == MASK_ADDR) begin
			state_next.mask = pwdata_in[PSC_BIT -: EVENT_W];
		end
		// Set beats clear; flags only gathered in satellite mode
		if (satellite_mode_in) begin
			state_next.events = state_next.events | pm_event;
		end
		state_next.irq = |(state_next.events & state_next.mask);
		// Burst read refused to a window with prefetch off
		state_next.refuse = burst_req_in & (burst_window_two_in ?
			state_next.win2_pd : state_next.win1_pd);
		// Read data, strobe bits always read back 0
		state_next.rdata = 32'h0;
		state_next.err = 1'b0;
		if (psel_in && !penable_in && !pwrite_in) begin
			if (paddr_in == CFG_ADDR) begin
				state_next.rdata[WIN1_PD_BIT] = state_reg.win1_pd;
				state_next.rdata[WIN2_PD_BIT] = state_reg.win2_pd;
			end else if (paddr_in == STAT_ADDR) begin
				state_next.rdata[PSC_BIT -: EVENT_W] = state_reg.events;
				state_next.rdata[M66_BIT] = state_reg.m66;
				state_next.rdata[IOBE_BIT] = state_reg.iobe;
				state_next.rdata[IIBE_BIT] = state_reg.iibe;
				state_next.rdata[TOBE_BIT] = tob_empty;
				state_next.rdata[TIBE_BIT] = tib_empty;
			end else if (paddr_in == MASK_ADDR) begin
				state_next.rdata[PSC_BIT -: EVENT_W] = state_reg.mask;
			end
		end
		if (psel_in && !penable_in) begin
			state_next.err = ~addr_hit(paddr_in);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg <= '{win1_pd: WIN1_PD_RESET, win2_pd: WIN2_PD_RESET,
				tob_strobe: 1'b0, tib_strobe: 1'b0, events: EVENT_RESET,
				mask: EVENT_RESET, m66: 1'b0, iobe: EMPTY_RESET,
				iibe: EMPTY_RESET, refuse: 1'b0, irq: 1'b0,
				rdata: 32'h0, err: 1'b0, ready: 1'b1, bar: 1'b1};
		end else if (clk_en_in) begin
			state_reg <= state_next;
		end
	end

	assign prdata_out = state_reg.rdata;
	assign pready_out = state_reg.ready;
	assign pslverr_out = state_reg.err;
	assign tgt_outbound_flush_out = tob_flush;
	assign tgt_inbound_flush_out = tib_flush;
	assign burst_refuse_out = state_reg.refuse;
	assign window_one_prefetch_off_out = state_reg.win1_pd;
	assign window_two_prefetch_off_out = state_reg.win2_pd;
	assign prefetchable_bar_out = state_reg.bar;
	assign irq_out = state_reg.irq;
endmodule

//--- tb/tgt_cfg_monitor.sv
// Purpose: port-level checker for the target config register bank
// Assumes: clk_en_in qualifies every antecedent that needs it
// Notes: attached by bind below
`timescale 1ns/1ps
module tgt_cfg_monitor (
	// Clock and APB
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [tgt_cfg_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	// Status and control
	input wire logic m66_enable_in,
	input wire logic init_outbound_empty_in,
	input wire logic init_inbound_empty_in,
	input wire logic tgt_outbound_flush_out,
	input wire logic tgt_inbound_flush_out,
	input wire logic burst_req_in,
	input wire logic burst_window_two_in,
	input wire logic burst_refuse_out,
	input wire logic window_one_prefetch_off_out,
	input wire logic window_two_prefetch_off_out,
	input wire logic prefetchable_bar_out
);
	import tgt_cfg_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	logic cfg_wr;
	logic stat_rd;
	logic req_off;
	logic [2:0] live;
	assign cfg_wr = psel_in && penable_in && pwrite_in && clk_en_in &&
		paddr_in == CFG_ADDR;
	assign stat_rd = psel_in && !penable_in && !pwrite_in && clk_en_in &&
		paddr_in == STAT_ADDR;
	assign req_off = burst_window_two_in ? window_two_prefetch_off_out :
		window_one_prefetch_off_out;
	assign live = {m66_enable_in, init_outbound_empty_in, init_inbound_empty_in};
	a_reset_prefetch: assert property ($fell(srst_in) |->
		!window_one_prefetch_off_out && window_two_prefetch_off_out)
		else $error("prefetch disables wrong after reset");
	a_cfg_write: assert property (cfg_wr |=>
		window_one_prefetch_off_out == $past(pwdata_in[11]) &&
		window_two_prefetch_off_out == $past(pwdata_in[10]))
		else $error("prefetch disable not written");
	a_burst_refuse: assert property (burst_req_in && clk_en_in |=>
		burst_refuse_out == $past(req_off)) else $error("burst refuse wrong");
	a_bar_fixed: assert property (
		$changed(window_one_prefetch_off_out) ||
		$changed(window_two_prefetch_off_out) |->
		$stable(prefetchable_bar_out) && prefetchable_bar_out)
		else $error("prefetchable bit moved");
	a_out_flush: assert property (cfg_wr && pwdata_in[9] |->
		##[1:2] tgt_outbound_flush_out) else $error("no outbound flush");
	a_in_flush: assert property (cfg_wr && pwdata_in[8] |->
		##[1:2] tgt_inbound_flush_out) else $error("no inbound flush");
	a_flush_reads0: assert property (psel_in && penable_in &&
		!pwrite_in && paddr_in == CFG_ADDR |-> prdata_out[9:8] == 2'b00)
		else $error("flush bits read nonzero");
	a_live_status: assert property (stat_rd |=>
		prdata_out[21:19] == $past(live)) else $error("live status wrong");
endmodule
bind tgt_cfg_regs tgt_cfg_monitor u_mon (.sys_clk_in, .srst_in, .clk_en_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
	.m66_enable_in, .init_outbound_empty_in, .init_inbound_empty_in,
	.tgt_outbound_flush_out, .tgt_inbound_flush_out, .burst_req_in,
	.burst_window_two_in, .burst_refuse_out, .window_one_prefetch_off_out,
	.window_two_prefetch_off_out, .prefetchable_bar_out);

//--- tb/pm_host_model.sv
// Purpose: host side writing the power-management control/status register
// Assumes: one write pulse per call
// Notes: enable value persists like the real register field
`timescale 1ns/1ps
module pm_host_model (
	// Clock
	input wire logic sys_clk_in,
	// Power-management writes
	output logic pmcsr_wr_out,
	output logic power_state_wr_out,
	output logic wake_enable_out,
	output logic wake_status_clr_out
);
	initial begin
		pmcsr_wr_out = 1'b0;
		power_state_wr_out = 1'b0;
		wake_enable_out = 1'b0;
		wake_status_clr_out = 1'b0;
	end
	// Idle gap lets the host be prompt or slow
	task automatic pm_write(input logic ps, input logic en, input logic clr,
		input int idle);
		@(posedge sys_clk_in);
		pmcsr_wr_out <= 1'b1;
		power_state_wr_out <= ps;
		wake_enable_out <= en;
		wake_status_clr_out <= clr;
		@(posedge sys_clk_in);
		pmcsr_wr_out <= 1'b0;
		power_state_wr_out <= 1'b0;
		wake_status_clr_out <= 1'b0;
		repeat (idle) @(posedge sys_clk_in);
	endtask
endmodule

//--- tb/pci_target_config_status_bits_tb.sv
// Purpose: self-checking bench for the target config register bank
// Assumes: 50 MHz clock, sync reset held 10 cycles
// Notes: clk_en_in driven by run, high except during one write made with it low
`timescale 1ns/1ps
module pci_target_config_status_bits_tb;
	import tgt_cfg_pkg::*;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [ADDR_W-1:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0;
	logic [31:0] prdata_out;
	logic [31:0] rd;
	logic pready_out, pslverr_out, err, sat = 1'b1;
	logic run = 1'b1;
	logic pm_wr, ps_wr, wake_en, wake_clr;
	logic [4:0] live = 5'h0F;
	logic [3:0] flow = '0;
	logic [1:0] burst = '0;
	logic tob_fl, tib_fl, refuse, win1, win2, bar, irq_out;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	pm_host_model u_host (.sys_clk_in(sys_clk_in), .pmcsr_wr_out(pm_wr),
		.power_state_wr_out(ps_wr), .wake_enable_out(wake_en),
		.wake_status_clr_out(wake_clr));
	tgt_cfg_regs u_dut (.sys_clk_in, .srst_in, .clk_en_in(run),
		.satellite_mode_in(sat), .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pmcsr_wr_in(pm_wr),
		.power_state_wr_in(ps_wr), .wake_enable_in(wake_en),
		.wake_status_clr_in(wake_clr), .m66_enable_in(live[4]),
		.init_outbound_empty_in(live[3]), .init_inbound_empty_in(live[2]),
		.tgt_outbound_empty_in(live[1]), .tgt_inbound_empty_in(live[0]),
		.tgt_outbound_done_in(flow[3]), .tgt_inbound_done_in(flow[2]),
		.tgt_outbound_push_in(flow[1]), .tgt_inbound_push_in(flow[0]),
		.tgt_outbound_flush_out(tob_fl), .tgt_inbound_flush_out(tib_fl),
		.burst_req_in(burst[1]), .burst_window_two_in(burst[0]),
		.burst_refuse_out(refuse), .window_one_prefetch_off_out(win1),
		.window_two_prefetch_off_out(win2), .prefetchable_bar_out(bar),
		.irq_out);
	initial forever #10 sys_clk_in = ~sys_clk_in;
	// Whole run needs well under 1000 cycles
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge sys_clk_in);
		flow <= v;
		@(posedge sys_clk_in);
		flow <= 4'h0;
		@(negedge sys_clk_in);
	endtask
	task automatic bchk(input logic w2, input logic exp);
		@(posedge sys_clk_in);
		burst <= {1'b1, w2};
		@(posedge sys_clk_in);
		burst <= 2'b00;
		@(negedge sys_clk_in);
		check({31'h0, refuse}, {31'h0, exp});
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		rchk(CFG_ADDR, 32'h0000_0400);
		rchk(STAT_ADDR, 32'h001E_0000);
		rchk(MASK_ADDR, 32'h0);
		rchk(16'hD09C, 32'h0);
		check({31'h0, err}, 32'h1);
		// Frozen clock enable must swallow the write
		run <= 1'b0;
		apb(1'b1, CFG_ADDR, 32'h0000_0800);
		run <= 1'b1;
		rchk(CFG_ADDR, 32'h0000_0400);
		$display("test reset done");
		apb(1'b1, CFG_ADDR, 32'h0000_0800);
		rchk(CFG_ADDR, 32'h0000_0800);
		bchk(1'b0, 1'b1);
		bchk(1'b1, 1'b0);
		check({31'h0, bar}, 32'h1);
		apb(1'b1, CFG_ADDR, 32'h0000_0400);
		bchk(1'b1, 1'b1);
		bchk(1'b0, 1'b0);
		check({31'h0, bar}, 32'h1);
		$display("test prefetch done");
		live <= 5'h0C;
		check({30'h0, tob_fl, tib_fl}, 32'h0);
		apb(1'b1, CFG_ADDR, 32'h0000_0700);
		rchk(CFG_ADDR, 32'h0000_0400);
		check({30'h0, tob_fl, tib_fl}, 32'h3);
		rchk(STAT_ADDR, 32'h0018_0000);
		pulse(4'hC);
		check({30'h0, tob_fl, tib_fl}, 32'h0);
		rchk(STAT_ADDR, 32'h001E_0000);
		pulse(4'h3);
		rchk(STAT_ADDR, 32'h0018_0000);
		live <= 5'h0F;
		$display("test flush done");
		u_host.pm_write(1'b1, 1'b0, 1'b0, 3);
		rchk(STAT_ADDR, 32'h011E_0000);
		check({31'h0, irq_out}, 32'h0);
		apb(1'b1, MASK_ADDR, 32'h01C0_0000);
		@(negedge sys_clk_in);
		check({31'h0, irq_out}, 32'h1);
		u_host.pm_write(1'b0, 1'b1, 1'b0, 0);
		rchk(STAT_ADDR, 32'h019E_0000);
		u_host.pm_write(1'b0, 1'b1, 1'b1, 3);
		rchk(STAT_ADDR, 32'h01DE_0000);
		apb(1'b1, STAT_ADDR, 32'h0);
		rchk(STAT_ADDR, 32'h01DE_0000);
		apb(1'b1, STAT_ADDR, 32'h013E_0000);
		rchk(STAT_ADDR, 32'h00DE_0000);
		apb(1'b1, STAT_ADDR, 32'h00C0_0000);
		rchk(STAT_ADDR, 32'h001E_0000);
		check({31'h0, irq_out}, 32'h0);
		sat <= 1'b0;
		u_host.pm_write(1'b1, 1'b0, 1'b1, 3);
		rchk(STAT_ADDR, 32'h001E_0000);
		live <= 5'h13;
		rchk(STAT_ADDR, 32'h0026_0000);
		$display("test power events done");
		tally_and_finish();
	end
endmodule
